// >>> logic/lp_cfg_pkg.sv
/*
 * Package for the low-power and core configuration register bank:
 * register offsets, field positions, reset values and carrier structs.
 * Assumes a 32-bit byte-addressed register port; offsets are byte addresses.
 */
`default_nettype none

package lp_cfg_pkg;

    localparam int          AW = 8;
    localparam logic [7:0]  LOW_POWER_CONTROL_OFS   = 8'h00;
    localparam logic [7:0]  CORE_CONFIG_CONTROL_OFS = 8'h04;
    localparam logic [7:0]  WAIT_STATUS_OFS         = 8'h08;

    localparam int WAKE_ON_ANY_PENDING_POS = 4;
    localparam int DEEP_SLEEP_SELECT_POS   = 2;
    localparam int SLEEP_ON_ISR_RETURN_POS = 1;

    localparam int BRANCH_GUESS_ON_POS        = 18;
    localparam int INSTR_CACHE_ENABLE_POS     = 17;
    localparam int DATA_CACHE_ENABLE_POS      = 16;
    localparam int STACK_ALIGN_8B_POS         = 9;
    localparam int HI_PRI_BUSFAULT_IGNORE_POS = 8;
    localparam int DIVZERO_TRAP_ENABLE_POS    = 4;

    localparam int STACKED_ALIGN_POS = 9;

    localparam logic [31:0] LOW_POWER_CONTROL_WMASK = 32'h0000_0016;
    localparam logic [31:0] LOW_POWER_CONTROL_RST   = 32'h0000_0000;
    localparam logic [31:0] CORE_CONFIG_RST         = 32'h0000_0000;

    typedef struct packed {
        logic wake_on_any_pending;
        logic deep_sleep_select;
        logic sleep_on_isr_return;
    } low_power_t;

    typedef struct packed {
        logic instr_cache_enable;
        logic data_cache_enable;
        logic hi_pri_busfault_ignore;
        logic divzero_trap_enable;
    } core_cfg_t;

    typedef struct packed {
        logic [lp_cfg_pkg::AW-1:0] addr;
        logic [31:0]               wdata;
        logic                      wr;
        logic                      rd;
    } reg_req_t;

endpackage

`default_nettype wire

// >>> logic/core_lowpower_config_regs.sv
/*
 * Low-power control and core configuration register bank with the wake,
 * sleep, bus-fault and divide-trap decisions it steers.
 * Assumes the core pipeline reports events, handler returns and faults as
 * one-cycle pulses on clk_i; the external event pin is asynchronous.
 */
// Implementation choices: the address map and the address-and-strobe port.
// Functional notes
// - wake_on_any_pending clear: only enabled interrupts or events wake the core
// - wake_on_any_pending set: events and all interrupts, disabled too, wake
// - newly pending event or interrupt raises the wake event signal
// - event arriving outside a wait is latched; next wait finishes at once
// - send event instruction or external event input also wakes the core
// - deep_sleep_select picks ordinary sleep (0) or deep sleep (1)
// - sleep_on_isr_return set: sleep on handler to thread return
// - branch_guess_on is read-only and always reads one
// - instr_cache_enable is read-write and enables the instruction cache
// - data_cache_enable is read-write and enables the data cache
// - stack_align_8b is read-only and always reads one
// - padding recorded in stacked status bit 9, used to restore on return
// - ignore clear: data bus fault at priority -1 or -2 causes lock-up
// - ignore set: priority -1 and -2 handlers ignore data bus faults
// - divzero_trap_enable chooses whether divide by zero traps
`timescale 1ns/1ps
`default_nettype none

module core_lowpower_config_regs #(
    parameter logic IC_PRESENT = 1'b1,
    parameter logic DC_PRESENT = 1'b1
) (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // register port
    input  wire lp_cfg_pkg::reg_req_t       req_i,
    output logic [31:0]                     rdata_o,
    // wake sources
    input  wire logic                       irq_pending_pulse_i,
    input  wire logic                       irq_enabled_i,
    input  wire logic                       event_pulse_i,
    input  wire logic                       send_event_i,
    input  wire logic                       ext_event_i,
    // wait, sleep and exception flow
    input  wire logic                       wfe_start_i,
    input  wire logic                       wfi_start_i,
    input  wire logic                       isr_return_i,
    input  wire logic                       exc_entry_i,
    input  wire logic                       sp_misaligned_i,
    input  wire logic                       exc_return_i,
    input  wire logic [31:0]                stacked_status_i,
    // faults
    input  wire logic                       data_busfault_i,
    input  wire logic                       hi_pri_level_i,
    input  wire logic                       div_zero_i,
    // core and power controller outputs
    output logic                            wfe_stall_o,
    output logic                            wake_o,
    output logic                            sleep_o,
    output logic                            deep_sleep_o,
    output logic                            icache_en_o,
    output logic                            dcache_en_o,
    output logic                            pad_flag_o,
    output logic                            sp_realign_o,
    output logic                            lockup_o,
    output logic                            busfault_ignored_o,
    output logic                            div_trap_o
);

    lp_cfg_pkg::low_power_t lp_q, lp_d;
    lp_cfg_pkg::core_cfg_t  cc_q, cc_d;
    logic [31:0] rdata_q, rdata_d;
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    logic event_latch_q, event_latch_d;
    logic stall_q, stall_d;
    logic sleep_q, sleep_d, deep_q, deep_d;
    logic wake_q, wake_d;
    logic pad_q, pad_d, realign_q, realign_d;
    logic lockup_q, lockup_d, bfign_q, bfign_d, divt_q, divt_d;
    logic wake_src;
    logic [31:0] lp_rd, cc_rd;

    // external event pin: two stages, third stage only for edge detection
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end
        else
        begin
            ext_s1_q <= ext_event_i;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // register reads: reserved bits are zero
    always_comb
    begin
        lp_rd = 32'h0000_0000;
        lp_rd[lp_cfg_pkg::WAKE_ON_ANY_PENDING_POS] = lp_q.wake_on_any_pending;
        lp_rd[lp_cfg_pkg::DEEP_SLEEP_SELECT_POS]   = lp_q.deep_sleep_select;
        lp_rd[lp_cfg_pkg::SLEEP_ON_ISR_RETURN_POS] = lp_q.sleep_on_isr_return;
        cc_rd = 32'h0000_0000;
        cc_rd[lp_cfg_pkg::BRANCH_GUESS_ON_POS]        = 1'b1;
        cc_rd[lp_cfg_pkg::INSTR_CACHE_ENABLE_POS]     = cc_q.instr_cache_enable;
        cc_rd[lp_cfg_pkg::DATA_CACHE_ENABLE_POS]      = cc_q.data_cache_enable;
        cc_rd[lp_cfg_pkg::STACK_ALIGN_8B_POS]         = 1'b1;
        cc_rd[lp_cfg_pkg::HI_PRI_BUSFAULT_IGNORE_POS] = cc_q.hi_pri_busfault_ignore;
        cc_rd[lp_cfg_pkg::DIVZERO_TRAP_ENABLE_POS]    = cc_q.divzero_trap_enable;
    end

    // register writes and read data
    always_comb
    begin
        lp_d    = lp_q;
        cc_d    = cc_q;
        rdata_d = 32'h0000_0000;
        if (req_i.wr && req_i.addr == lp_cfg_pkg::LOW_POWER_CONTROL_OFS)
        begin
            lp_d.wake_on_any_pending = req_i.wdata[lp_cfg_pkg::WAKE_ON_ANY_PENDING_POS];
            lp_d.deep_sleep_select   = req_i.wdata[lp_cfg_pkg::DEEP_SLEEP_SELECT_POS];
            lp_d.sleep_on_isr_return = req_i.wdata[lp_cfg_pkg::SLEEP_ON_ISR_RETURN_POS];
        end
        else if (req_i.wr && req_i.addr == lp_cfg_pkg::CORE_CONFIG_CONTROL_OFS)
        begin
            // absent caches keep their bit at zero
            lp_d = lp_q;
            cc_d.instr_cache_enable =
                IC_PRESENT & req_i.wdata[lp_cfg_pkg::INSTR_CACHE_ENABLE_POS];
            cc_d.data_cache_enable =
                DC_PRESENT & req_i.wdata[lp_cfg_pkg::DATA_CACHE_ENABLE_POS];
            cc_d.hi_pri_busfault_ignore =
                req_i.wdata[lp_cfg_pkg::HI_PRI_BUSFAULT_IGNORE_POS];
            cc_d.divzero_trap_enable = req_i.wdata[lp_cfg_pkg::DIVZERO_TRAP_ENABLE_POS];
        end
        if (req_i.rd)
        begin
            if (req_i.addr == lp_cfg_pkg::LOW_POWER_CONTROL_OFS)
                rdata_d = lp_rd;
            else if (req_i.addr == lp_cfg_pkg::CORE_CONFIG_CONTROL_OFS)
                rdata_d = cc_rd;
            else if (req_i.addr == lp_cfg_pkg::WAIT_STATUS_OFS)
                rdata_d = {28'h000_0000, sleep_q, deep_q, stall_q, event_latch_q};
            else
                rdata_d = 32'h0000_0000;
        end
    end

    // wake, wait and sleep control
    always_comb
    begin
        // disabled interrupts count only with wake_on_any_pending set
        wake_src = event_pulse_i | send_event_i | (ext_s2_q & ~ext_s3_q)
                 | (irq_pending_pulse_i
                    & (irq_enabled_i | lp_q.wake_on_any_pending));
        event_latch_d = event_latch_q;
        stall_d       = stall_q;
        wake_d        = 1'b0;
        sleep_d       = sleep_q;
        deep_d        = deep_q;
        if (stall_q)
        begin
            if (wake_src)
            begin
                stall_d = 1'b0;
                wake_d  = 1'b1;
            end
        end
        else if (wfe_start_i)
        begin
            // a latched event lets the wait finish with no stall
            if (event_latch_q || wake_src)
            begin
                event_latch_d = 1'b0;
                wake_d        = 1'b1;
            end
            else
                stall_d = 1'b1;
        end
        else if (wake_src)
            event_latch_d = 1'b1;
        // deep sleep holds sleep_q low, so both states must answer a wake
        if ((sleep_q || deep_q) && wake_src)
        begin
            sleep_d = 1'b0;
            deep_d  = 1'b0;
            wake_d  = 1'b1;
        end
        else if (wfi_start_i || (isr_return_i && lp_q.sleep_on_isr_return))
        begin
            sleep_d = ~lp_q.deep_sleep_select;
            deep_d  = lp_q.deep_sleep_select;
        end
    end

    // fault, divide and stack alignment decisions
    always_comb
    begin
        lockup_d  = lockup_q | (data_busfault_i & hi_pri_level_i
                               & ~cc_q.hi_pri_busfault_ignore);
        bfign_d   = data_busfault_i & hi_pri_level_i
                  & cc_q.hi_pri_busfault_ignore;
        divt_d    = div_zero_i & cc_q.divzero_trap_enable;
        pad_d     = exc_entry_i ? sp_misaligned_i : pad_q;
        realign_d = exc_return_i & stacked_status_i[lp_cfg_pkg::STACKED_ALIGN_POS];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lp_q          <= lp_cfg_pkg::low_power_t'(3'h0);
            cc_q          <= lp_cfg_pkg::core_cfg_t'(4'h0);
            rdata_q       <= 32'h0000_0000;
            event_latch_q <= 1'b0;
            stall_q       <= 1'b0;
            wake_q        <= 1'b0;
            sleep_q       <= 1'b0;
            deep_q        <= 1'b0;
            pad_q         <= 1'b0;
            realign_q     <= 1'b0;
            lockup_q      <= 1'b0;
            bfign_q       <= 1'b0;
            divt_q        <= 1'b0;
        end
        else
        begin
            lp_q          <= lp_d;
            cc_q          <= cc_d;
            rdata_q       <= rdata_d;
            event_latch_q <= event_latch_d;
            stall_q       <= stall_d;
            wake_q        <= wake_d;
            sleep_q       <= sleep_d;
            deep_q        <= deep_d;
            pad_q         <= pad_d;
            realign_q     <= realign_d;
            lockup_q      <= lockup_d;
            bfign_q       <= bfign_d;
            divt_q        <= divt_d;
        end
    end

    assign rdata_o            = rdata_q;
    assign wfe_stall_o        = stall_q;
    assign wake_o             = wake_q;
    assign sleep_o            = sleep_q;
    assign deep_sleep_o       = deep_q;
    assign icache_en_o        = cc_q.instr_cache_enable;
    assign dcache_en_o        = cc_q.data_cache_enable;
    assign pad_flag_o         = pad_q;
    assign sp_realign_o       = realign_q;
    assign lockup_o           = lockup_q;
    assign busfault_ignored_o = bfign_q;
    assign div_trap_o         = divt_q;

    // checks
    ro_ones_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == lp_cfg_pkg::CORE_CONFIG_CONTROL_OFS
        |=> rdata_o[18] && rdata_o[9])
        else $error("read-only ones missing");
    reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == lp_cfg_pkg::LOW_POWER_CONTROL_OFS
        |=> (rdata_o & 32'hFFFF_FFE9) == 32'h0000_0000)
        else $error("reserved bits not zero");
    disabled_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        stall_q && irq_pending_pulse_i && !irq_enabled_i && !lp_q.wake_on_any_pending
        && !event_pulse_i && !send_event_i && !(ext_s2_q && !ext_s3_q) |=> stall_q)
        else $error("disabled interrupt woke core");
    any_pend_a: assert property (@(posedge clk_i) disable iff (rst_i)
        stall_q && irq_pending_pulse_i && lp_q.wake_on_any_pending
        |=> !stall_q && wake_o)
        else $error("pending interrupt did not wake");
    latched_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
        event_latch_q && !stall_q && wfe_start_i |=> wake_o && !stall_q && !event_latch_q)
        else $error("latched event ignored");
    sev_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
        stall_q && send_event_i |=> wake_o)
        else $error("send event did not wake");
    sleep_kind_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !sleep_q && !deep_q && wfi_start_i |=> deep_sleep_o == $past(lp_q.deep_sleep_select)
        && sleep_o == !$past(lp_q.deep_sleep_select))
        else $error("wrong sleep kind");
    isr_return_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !sleep_q && !deep_q && !wfi_start_i && isr_return_i && !lp_q.sleep_on_isr_return
        |=> !sleep_o && !deep_sleep_o)
        else $error("slept on return");
    lockup_a: assert property (@(posedge clk_i) disable iff (rst_i)
        data_busfault_i && hi_pri_level_i && !cc_q.hi_pri_busfault_ignore
        |=> lockup_o [*2])
        else $error("no lockup");
    bf_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
        data_busfault_i && hi_pri_level_i && cc_q.hi_pri_busfault_ignore
        |=> busfault_ignored_o && lockup_o == $past(lockup_o))
        else $error("busfault not ignored");
    div_trap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        div_zero_i |=> div_trap_o == $past(cc_q.divzero_trap_enable))
        else $error("divide trap wrong");
    realign_a: assert property (@(posedge clk_i) disable iff (rst_i)
        exc_entry_i |=> pad_flag_o == $past(sp_misaligned_i))
        else $error("pad flag not recorded");
    wfe_wake_c: cover property (@(posedge clk_i) disable iff (rst_i)
        wfe_start_i ##1 stall_q [*2] ##1 wake_o);
    deep_c: cover property (@(posedge clk_i) disable iff (rst_i) deep_sleep_o ##[1:20] wake_o);
    exit_sleep_c: cover property (@(posedge clk_i) disable iff (rst_i)
        isr_return_i && lp_q.sleep_on_isr_return ##1 sleep_o);

endmodule

`default_nettype wire

// >>> dv/core_pipe_model.sv
/*
 * Core pipeline and power controller stand-in: one-cycle request pulses,
 * qualifying levels and the asynchronous external event pin.
 * Assumes the bench calls its tasks and that clk_i is the bank's clock.
 */
`timescale 1ns/1ps
`default_nettype none

module core_pipe_model (
    // clock
    input  wire logic        clk_i,
    // one-cycle pulses toward the bank
    output logic [9:0]       pulse_o,
    // qualifying levels
    output logic             irq_enabled_o,
    output logic             sp_misaligned_o,
    output logic             hi_pri_level_o,
    output logic [31:0]      stacked_status_o,
    // asynchronous event pin
    output logic             ext_event_o
);
    initial
    begin
        pulse_o = '0;
        irq_enabled_o = 1'b0;
        sp_misaligned_o = 1'b0;
        hi_pri_level_o = 1'b0;
        stacked_status_o = 32'h0000_0000;
        ext_event_o = 1'b0;
    end

    task automatic fire(input int idx);
        @(posedge clk_i);
        pulse_o[idx] <= 1'b1;
        @(posedge clk_i);
        pulse_o[idx] <= 1'b0;
    endtask

    task automatic set_lv(input logic en, input logic mis, input logic hi, input logic [31:0] st);
        @(posedge clk_i);
        irq_enabled_o <= en;
        sp_misaligned_o <= mis;
        hi_pri_level_o <= hi;
        stacked_status_o <= st;
    endtask

    // pin changes off the clock edge, held long enough for the synchroniser
    task automatic ext_event();
        #3;
        ext_event_o = 1'b1;
        repeat (4) @(posedge clk_i);
        #3;
        ext_event_o = 1'b0;
    endtask
endmodule

`default_nettype wire

// >>> dv/core_lowpower_config_regs_tb.sv
/*
 * Self-checking bench for the low-power and core configuration bank.
 * Assumes the core model sits on the event and exception side.
 */
`timescale 1ns/1ps
`default_nettype none

module core_lowpower_config_regs_tb;
    localparam int IRQ = 0, EVT = 1, SEND_EVENT_INSTR = 2, WAIT_FOR_EVENT_INSTR = 3, WFI = 4;
    localparam int ISR = 5, ENT = 6, RET = 7, BF = 8, DIV = 9;
    localparam logic [8:0] WK = 9'h001, ST = 9'h002, SL = 9'h004, DS = 9'h008, PAD = 9'h010;
    localparam logic [8:0] RA = 9'h020, LK = 9'h040, BI = 9'h080, DT = 9'h100;

    logic                  clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    lp_cfg_pkg::reg_req_t  req = '0;
    logic [31:0]           rdata_o;
    logic [9:0]            p;
    logic                  irq_en, mis, hi, ext_ev;
    logic [31:0]           stk;
    wire  [8:0]            obs;
    logic [8:0]            seen_v;
    int                    errors = 0;
    int                    checks_done = 0;
    int                    cycles = 0;

    always #5 clk_i = ~clk_i;

    core_pipe_model core (.clk_i(clk_i), .pulse_o(p), .irq_enabled_o(irq_en),
        .sp_misaligned_o(mis), .hi_pri_level_o(hi), .stacked_status_o(stk), .ext_event_o(ext_ev));

    core_lowpower_config_regs dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata_o),
        .irq_pending_pulse_i(p[IRQ]), .irq_enabled_i(irq_en), .event_pulse_i(p[EVT]),
        .send_event_i(p[SEND_EVENT_INSTR]), .ext_event_i(ext_ev), .wfe_start_i(p[WAIT_FOR_EVENT_INSTR]), .wfi_start_i(p[WFI]),
        .isr_return_i(p[ISR]), .exc_entry_i(p[ENT]), .sp_misaligned_i(mis),
        .exc_return_i(p[RET]), .stacked_status_i(stk), .data_busfault_i(p[BF]),
        .hi_pri_level_i(hi), .div_zero_i(p[DIV]), .wfe_stall_o(obs[1]), .wake_o(obs[0]),
        .sleep_o(obs[2]), .deep_sleep_o(obs[3]), .icache_en_o(), .dcache_en_o(),
        .pad_flag_o(obs[4]), .sp_realign_o(obs[5]), .lockup_o(obs[6]),
        .busfault_ignored_o(obs[7]), .div_trap_o(obs[8]));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_i);
        req <= '{addr: a, wdata: d, wr: wr, rd: ~wr};
        @(posedge clk_i);
        req <= '0;
        #1;
        q = rdata_o;
    endtask

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q, exp);
    endtask

    // ors the observed outputs over a window; pulses are not missed
    task automatic look(input logic [8:0] m, input logic [8:0] e);
        seen_v = '0;
        repeat (10)
        begin
            #1;
            seen_v = seen_v | obs;
            @(posedge clk_i);
        end
        check({23'h0, seen_v & m}, {23'h0, e});
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            conclude();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(8'h00, 32'h0000_0000);
        rd_chk(8'h04, 32'h0004_0200);
        wr32(8'h00, 32'hFFFF_FFFF);
        rd_chk(8'h00, 32'h0000_0016);
        wr32(8'h04, 32'hFFFF_FFFF);
        rd_chk(8'h04, 32'h0007_0310);
        check({30'h0, dut.icache_en_o, dut.dcache_en_o}, 32'h0000_0003);
        wr32(8'hFC, 32'hFFFF_FFFF);
        rd_chk(8'hFC, 32'h0000_0000);
        wr32(8'h04, 32'h0000_0000);
        rd_chk(8'h04, 32'h0004_0200);
        wr32(8'h00, 32'h0000_0000);
        core.fire(WAIT_FOR_EVENT_INSTR);
        look(ST | WK, ST);
        rd_chk(8'h08, 32'h0000_0002);
        core.fire(IRQ);
        look(WK, 9'h000);
        core.set_lv(1'b1, 1'b0, 1'b0, 32'h0000_0000);
        core.fire(IRQ);
        look(WK, WK);
        wr32(8'h00, 32'h0000_0010);
        core.set_lv(1'b0, 1'b0, 1'b0, 32'h0000_0000);
        core.fire(WAIT_FOR_EVENT_INSTR);
        core.fire(IRQ);
        look(WK, WK);
        core.fire(WAIT_FOR_EVENT_INSTR);
        core.fire(SEND_EVENT_INSTR);
        look(WK, WK);
        core.fire(WAIT_FOR_EVENT_INSTR);
        fork
            core.ext_event();
        join_none
        look(WK, WK);
        core.fire(EVT);
        look(WK | ST, 9'h000);
        core.fire(WAIT_FOR_EVENT_INSTR);
        look(WK | ST, WK);
        core.set_lv(1'b1, 1'b0, 1'b0, 32'h0000_0000);
        wr32(8'h00, 32'h0000_0000);
        core.fire(WFI);
        look(SL | DS, SL);
        core.fire(IRQ);
        look(WK, WK);
        check({31'h0, obs[2]}, 32'h0000_0000);
        wr32(8'h00, 32'h0000_0004);
        core.fire(WFI);
        look(SL | DS, DS);
        core.fire(IRQ);
        look(WK | DS, WK);
        core.fire(ISR);
        look(SL | DS, 9'h000);
        wr32(8'h00, 32'h0000_0002);
        core.fire(ISR);
        look(SL | DS, SL);
        core.fire(IRQ);
        look(WK, WK);
        core.set_lv(1'b1, 1'b1, 1'b0, 32'h0000_0200);
        core.fire(ENT);
        look(PAD, PAD);
        core.fire(RET);
        look(RA, RA);
        core.set_lv(1'b1, 1'b0, 1'b0, 32'hFFFF_FDFF);
        core.fire(RET);
        look(RA, 9'h000);
        core.fire(ENT);
        look(RA, 9'h000);
        check({31'h0, obs[4]}, 32'h0000_0000);
        // ignore bit only around safe probing code
        wr32(8'h04, 32'h0000_0100);
        core.set_lv(1'b1, 1'b0, 1'b1, 32'h0000_0000);
        core.fire(BF);
        look(BI | LK, BI);
        core.fire(DIV);
        look(DT, 9'h000);
        wr32(8'h04, 32'h0000_0010);
        core.fire(DIV);
        look(DT, DT);
        core.fire(BF);
        look(BI | LK, LK);
        conclude();
    end
endmodule

`default_nettype wire
